// >>> hw/fifo_cfg_ctrl.sv
// Configuration, offset programming and read-port control of the FIFO
`timescale 1ns/1ps
`default_nettype none

module fifo_cfg_ctrl #(
  parameter int unsigned DEPTH = 4
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        full_reset_n,
  input  wire logic        data_only_reset_n,
  input  wire logic        write_side_clock,
  input  wire logic        write_request_n,
  input  wire logic [71:0] data_in,
  input  wire logic        read_side_clock,
  input  wire logic        read_request_n,
  input  wire logic        read_port_select,
  input  wire logic        output_drive_enable,
  input  wire logic        serial_program_clock,
  input  wire logic        serial_load_enable,
  input  wire logic        offset_load_select,
  input  wire logic        mode_serial_in,
  input  wire logic        default_offset_sel0,
  input  wire logic        default_offset_sel1,
  input  wire logic        width_match_enable,
  input  wire logic        in_width_sel,
  input  wire logic        out_width_sel,
  input  wire logic        byte_order_select,
  input  wire logic        flag_timing_select,
  input  wire logic        parity_placement_select,
  input  wire logic        read_port_level_select,
  output logic      [71:0] q_out,
  output logic             q_oe,
  output logic             no_data_flag,
  output logic             near_empty_flag,
  output logic             near_full_flag,
  output logic             echo_clock,
  output logic             echo_read_enable,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  localparam int unsigned OW = fifo_cfg_pkg::OFS_W;
  localparam int unsigned LW = OW + 1;
  localparam int unsigned AW = $clog2(DEPTH);

  // Depth must be a power of two and its unit count fit the offsets
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH * 4 + 1 >= (1 << OW))
  begin : g_bad_depth
    $error("DEPTH must be a power of two with DEPTH*4+1 below offset range");
  end

  // ============================================================
  // Pin synchronisers
  logic [20:0] ps;
  logic [20:0] pr;
  logic [71:0] din;
  logic wclk_s, rclk_s, sclk_s, wreq_s, rreq_s, rps_s, oe_s, sen_s, ld_s, si_s;
  logic mrs_s, prs_s, fs0_s, fs1_s, bm_s, iw_s, ow_s, be_s, pfm_s, ip_s, lvl_s;

  pin_sync #(.W(21)) u_ctl_sync (
    .mclk (mclk),
    .rst_n(rst_n),
    .d    ({read_port_level_select, parity_placement_select, flag_timing_select,
            byte_order_select, out_width_sel, in_width_sel, width_match_enable,
            default_offset_sel1, default_offset_sel0, data_only_reset_n,
            full_reset_n, mode_serial_in, offset_load_select, serial_load_enable,
            output_drive_enable, read_port_select, read_request_n,
            write_request_n, serial_program_clock, read_side_clock,
            write_side_clock}),
    .q    (ps),
    .rise (pr)
  );

  // Data goes through the same two stages so it lines up with its strobe
  pin_sync #(.W(72)) u_dat_sync (
    .mclk (mclk),
    .rst_n(rst_n),
    .d    (data_in),
    .q    (din),
    .rise ()
  );

  assign {lvl_s, ip_s, pfm_s, be_s, ow_s, iw_s, bm_s, fs1_s, fs0_s, prs_s, mrs_s,
          si_s, ld_s, sen_s, oe_s, rps_s, rreq_s, wreq_s, sclk_s, rclk_s,
          wclk_s} = ps;

  logic w_edge, r_edge, s_edge, clr;
  assign w_edge = pr[0];
  assign r_edge = pr[1];
  assign s_edge = pr[2];
  assign clr    = ~mrs_s | ~prs_s;

  // ============================================================
  // Configuration straps, caught while full reset is held
  logic       ft_q, ser_q, bm_q, iw_q, ow_q, be_q, pfm_q, ip_q, lvl_q;
  logic [2:0] idx_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {ft_q, ser_q, bm_q, iw_q, ow_q, be_q, pfm_q, ip_q, lvl_q} <= '0;
      idx_q <= '0;
    end
    else if (!mrs_s) // Only full reset changes them; data reset does not
    begin
      ft_q  <= si_s;
      ser_q <= ~ld_s;
      idx_q <= {ld_s, fs1_s, fs0_s};
      {bm_q, iw_q, ow_q} <= {bm_s, iw_s, ow_s};
      be_q  <= be_s;
      pfm_q <= pfm_s;
      ip_q  <= ip_s;
      lvl_q <= lvl_s;
    end
  end

  // ============================================================
  // Width conversion helpers
  logic [2:0] in_ratio, out_ratio;
  assign in_ratio  = (bm_q & iw_q)  ? (ow_q ? 3'h4 : 3'h2) : 3'h1;
  assign out_ratio = (bm_q & ~iw_q) ? (ow_q ? 3'h4 : 3'h2) : 3'h1;

  function automatic logic [71:0] lane_mask(input logic [2:0] r, input logic x18);
    lane_mask = (r == 3'h1) ? {72{1'b1}} :
                x18 ? {54'h0, {18{1'b1}}} : {36'h0, {36{1'b1}}};
  endfunction

  // Big order puts part 0 in the top lane
  function automatic logic [6:0] lane_sh(input logic [1:0] k, input logic [2:0] r,
                                         input logic big, input logic x18);
    logic [1:0] lane;
    lane    = big ? 2'(r - 3'h1 - {1'b0, k}) : k;
    lane_sh = x18 ? 7'(lane * fifo_cfg_pkg::LANE_X18)
                  : 7'(lane * fifo_cfg_pkg::LANE_X36);
  endfunction

  // Drop the parity positions in interspersed mode
  function automatic logic [63:0] strip(input logic [71:0] d, input logic ip);
    logic [63:0] r;
    r = d[63:0];
    if (ip)
    begin
      for (int g = 0; g < 8; g++)
        r[g*8 +: 8] = d[g*9 +: 8];
    end
    strip = r;
  endfunction

  // ============================================================
  // Strobes and offset access
  logic wr_strobe, rd_strobe, par_wr, ofs_rd, ser_shift, wsel_q, rsel_q;
  assign wr_strobe = w_edge & ~wreq_s;
  assign rd_strobe = r_edge & ~rreq_s & ~rps_s;
  assign par_wr    = wr_strobe & ~ld_s & ~ser_q & mrs_s;
  assign ofs_rd    = rd_strobe & ~ld_s & mrs_s;
  assign ser_shift = s_edge & ~sen_s & ~ld_s & ser_q & mrs_s;

  // Alternate empty then full offset; restart when load select rises
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
    end
    else if (ld_s)
    begin
      wsel_q <= 1'b0;
      rsel_q <= 1'b0;
    end
    else
    begin
      if (par_wr)
        wsel_q <= ~wsel_q;
      if (ofs_rd)
        rsel_q <= ~rsel_q;
    end
  end

  // ============================================================
  // Offset registers
  logic [OW-1:0] empty_q, full_q, par_val;
  logic          bus_req, bus_wr;
  logic [OW-1:0] wb_val_e, wb_val_f;
  logic [63:0]   stripped;
  // A function result cannot be part-selected, so it lands in a net first
  assign stripped = strip(din, ip_q);
  assign par_val  = stripped[OW-1:0];
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign wb_val_e = {wb_sel_i[1] ? wb_dat_i[9:8] : empty_q[9:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : empty_q[7:0]};
  assign wb_val_f = {wb_sel_i[1] ? wb_dat_i[9:8] : full_q[9:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : full_q[7:0]};

  // Pins win over the bus; data-only reset leaves offsets alone
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      empty_q <= fifo_cfg_pkg::OFS_RST;
      full_q  <= fifo_cfg_pkg::OFS_RST;
    end
    else if (!mrs_s)
    begin
      empty_q <= fifo_cfg_pkg::DEF_OFS[{ld_s, fs1_s, fs0_s}];
      full_q  <= fifo_cfg_pkg::DEF_OFS[{ld_s, fs1_s, fs0_s}];
    end
    else if (ser_shift) // Empty LSB first, full MSB last
      {full_q, empty_q} <= {si_s, full_q, empty_q[OW-1:1]};
    else if (par_wr)
    begin
      if (wsel_q)
        full_q <= par_val;
      else
        empty_q <= par_val;
    end
    else if (bus_wr && wb_adr_i == fifo_cfg_pkg::REG_EMPTY_OFS)
      empty_q <= wb_val_e;
    else if (bus_wr && wb_adr_i == fifo_cfg_pkg::REG_FULL_OFS)
      full_q <= wb_val_f;
  end

  // ============================================================
  // Write side packing and word store
  logic [71:0] pack_q, pack_d, mem_q [DEPTH];
  logic [1:0]  in_part_q;
  logic [6:0]  in_sh;
  logic        mem_wr, word_done, push, pop;
  logic [AW:0] cnt_q;
  logic [AW-1:0] wp_q, rp_q;

  assign mem_wr    = wr_strobe & ld_s & ~clr; // Memory writes need load high
  assign in_sh     = lane_sh(in_part_q, in_ratio, ~be_q, ow_q);
  assign pack_d    = (pack_q & ~(lane_mask(in_ratio, ow_q) << in_sh)) |
                     ((din & lane_mask(in_ratio, ow_q)) << in_sh);
  assign word_done = mem_wr & (in_part_q == 2'(in_ratio - 3'h1));
  assign push      = word_done & (cnt_q != (AW+1)'(DEPTH));

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pack_q    <= '0;
      in_part_q <= '0;
    end
    else if (clr)
    begin
      pack_q    <= '0;
      in_part_q <= '0;
    end
    else if (mem_wr)
    begin
      pack_q    <= pack_d;
      in_part_q <= word_done ? 2'h0 : in_part_q + 2'h1;
    end
  end

  // Storage array holds data only, so it carries no reset
  always_ff @(posedge mclk)
  begin
    if (push)
      mem_q[wp_q] <= pack_d;
  end

  // Pointers and word count
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      wp_q  <= '0;
      rp_q  <= '0;
    end
    else if (clr)
    begin
      cnt_q <= '0;
      wp_q  <= '0;
      rp_q  <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
    end
  end

  // ============================================================
  // Read side: output register, fall-through and part splitting
  logic [71:0] cur_q, out_q, src;
  logic [1:0]  rem_q, ftc_q, k;
  logic        ov_q, avail, ft_fall, adv, adv_ft;

  assign avail   = (rem_q != 2'h0) | (cnt_q != '0);
  // Fall-through ignores select and request
  assign ft_fall = ft_q & r_edge & ~ov_q & (cnt_q != '0) &
                   (ftc_q == 2'(fifo_cfg_pkg::FT_EDGES - 1));
  assign adv_ft  = ft_q & rd_strobe & ld_s & ov_q;
  assign adv     = ~clr & ((~ft_q & rd_strobe & ld_s & avail) | ft_fall |
                           (adv_ft & avail));
  assign pop     = adv & (rem_q == 2'h0);
  assign src     = (rem_q != 2'h0) ? cur_q : mem_q[rp_q];
  assign k       = (rem_q != 2'h0) ? 2'(out_ratio - {1'b0, rem_q}) : 2'h0;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= '0;
      cur_q <= '0;
      rem_q <= '0;
      ov_q  <= 1'b0;
    end
    else if (clr)
    begin
      out_q <= '0;
      cur_q <= '0;
      rem_q <= '0;
      ov_q  <= 1'b0;
    end
    else if (ofs_rd) // Offsets always read in parallel
      out_q <= {{(72 - OW){1'b0}}, rsel_q ? full_q : empty_q};
    else if (adv)
    begin
      out_q <= (src >> lane_sh(k, out_ratio, ~be_q, ow_q)) &
               lane_mask(out_ratio, ow_q);
      ov_q  <= 1'b1;
      if (rem_q != 2'h0)
        rem_q <= rem_q - 2'h1;
      else
      begin
        cur_q <= mem_q[rp_q];
        rem_q <= 2'(out_ratio - 3'h1);
      end
    end
    else if (adv_ft)
      ov_q <= 1'b0;
  end

  // Count read edges while a word waits to fall through
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ftc_q <= '0;
    else if (clr || ft_fall)
      ftc_q <= '0;
    else if (r_edge)
      ftc_q <= (ft_q & ~ov_q & (cnt_q != '0)) ? ftc_q + 2'h1 : 2'h0;
  end

  // ============================================================
  // Flags, counted in output units
  logic [LW-1:0] level, cap;
  logic ae_cond, af_cond, nd_q, ne_q, nf_q;
  assign level = LW'(cnt_q) * LW'(out_ratio) + LW'(rem_q) + LW'(ft_q & ov_q);
  assign cap   = LW'(DEPTH) * LW'(out_ratio) + LW'(ft_q);
  assign ae_cond = level <= LW'(empty_q);
  assign af_cond = (level + LW'(full_q)) >= cap;

  // Flags follow read edges whatever the port select does
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      nd_q <= 1'b0;
      ne_q <= 1'b0;
      nf_q <= 1'b1;
    end
    else if (clr)
    begin
      nd_q <= 1'b0;
      ne_q <= 1'b0;
      nf_q <= 1'b1;
    end
    else
    begin
      if (r_edge)
        nd_q <= ft_q ? (ov_q | ft_fall) : (cnt_q != '0 || rem_q != 2'h0);
      if (pfm_q)
      begin
        if (r_edge)
          ne_q <= ~ae_cond;
        if (w_edge)
          nf_q <= ~af_cond;
      end
      else
      begin
        // Set and release need opposite conditions, so both clocks landing together never clash
        if (r_edge && ae_cond)
          ne_q <= 1'b0;
        if (w_edge && !ae_cond)
          ne_q <= 1'b1;
        if (w_edge && af_cond)
          nf_q <= 1'b0;
        if (r_edge && !af_cond)
          nf_q <= 1'b1;
      end
    end
  end

  // ============================================================
  // Output drive control
  logic hold_q, drive_q;

  // Reset keeps the bus driven until the first read edge after it
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_q  <= 1'b1;
      drive_q <= 1'b0;
    end
    else if (clr)
      hold_q <= 1'b1;
    else if (r_edge)
    begin
      hold_q  <= 1'b0;
      drive_q <= ~rps_s;
    end
  end

  assign q_oe = ~oe_s & (hold_q | drive_q);
  assign q_out = out_q;
  assign no_data_flag    = nd_q;
  assign near_empty_flag = ne_q;
  assign near_full_flag  = nf_q;

  // Echo outputs exist only for the high-speed read level
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      echo_clock       <= 1'b0;
      echo_read_enable <= 1'b0;
    end
    else
    begin
      echo_clock       <= lvl_q & rclk_s;
      echo_read_enable <= lvl_q & ~rreq_s;
    end
  end

  // ============================================================
  // Wishbone slave: one registered ack a cycle after the request, unmapped reads return zero
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      if (bus_req)
        unique case (wb_adr_i)
          fifo_cfg_pkg::REG_STATUS:
            wb_dat_o <= {5'h0, level, idx_q, lvl_q, ow_q, iw_q, bm_q, be_q, ip_q,
                         pfm_q, ser_q, ft_q, ov_q, nf_q, ne_q, nd_q};
          fifo_cfg_pkg::REG_EMPTY_OFS: wb_dat_o <= {22'h0, empty_q};
          fifo_cfg_pkg::REG_FULL_OFS:  wb_dat_o <= {22'h0, full_q};
          default:                     wb_dat_o <= '0;
        endcase
    end
  end

  // ============================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence ft_last_edge;
    ft_q && !ov_q && cnt_q != '0 && r_edge && ftc_q == 2'h2 && !clr;
  endsequence

  chk_sen_blocks_ofs: assert property (s_edge && sen_s && mrs_s && !par_wr && !bus_wr
    |=> $stable(empty_q) && $stable(full_q)) else $error("offset changed with sen high");
  chk_oe_floats_bus: assert property (oe_s |-> !q_oe)
    else $error("bus driven with drive enable high");
  chk_reset_drive: assert property (clr && !oe_s |=> q_oe)
    else $error("bus floated during reset");
  chk_rps_floats: assert property (r_edge && rps_s && !clr |=> !q_oe)
    else $error("bus not floated after deselect edge");
  chk_rps_drives: assert property (r_edge && !rps_s && !clr ##1 !oe_s |-> q_oe)
    else $error("bus not driven after select edge");
  chk_flag_indep: assert property (!ft_q && r_edge && cnt_q != '0 && !clr |=> nd_q)
    else $error("empty flag missed a read edge");
  chk_echo_off: assert property (!lvl_q && $past(!lvl_q)
    |-> !echo_clock && !echo_read_enable) else $error("echo active in low level mode");
  chk_ft_third: assert property (ft_last_edge |=> ov_q && nd_q)
    else $error("fall-through word missing at third edge");
  chk_sync_flag: assert property (pfm_q && w_edge && !r_edge && !clr |=> $stable(ne_q))
    else $error("sync empty-side flag moved on write edge");
  chk_cfg_hold: assert property (mrs_s && $past(mrs_s)
    |-> $stable({ft_q, ser_q, idx_q, be_q})) else $error("straps changed outside full reset");

endmodule

`default_nettype wire

// >>> hw/fifo_cfg_pkg.sv
// Constants shared by the FIFO configuration and read-port control block
// ============================================================

package fifo_cfg_pkg;

  localparam int unsigned WORD_W   = 72;
  localparam int unsigned OFS_W    = 10;
  localparam int unsigned FT_EDGES = 3;
  localparam int unsigned LANE_X36 = 36;
  localparam int unsigned LANE_X18 = 18;

  // Register byte addresses
  localparam logic [7:0] REG_STATUS    = 8'h00;
  localparam logic [7:0] REG_EMPTY_OFS = 8'h04;
  localparam logic [7:0] REG_FULL_OFS  = 8'h08;

  // Eight default offsets, chosen by the reset straps
  localparam logic [OFS_W-1:0] DEF_OFS [8] = '{
    10'h007, 10'h00f, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h1ff, 10'h3ff
  };

  // Reset value of the offset registers before straps are seen
  localparam logic [OFS_W-1:0] OFS_RST = 10'h007;

endpackage

// >>> hw/pin_sync.sv
// Two-flop synchroniser with rising-edge pulse for a group of pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // ============================================================
  // Synchroniser; first stage feeds only the second
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q    = sync_q;
  assign rise = sync_q & ~prev_q;

endmodule

`default_nettype wire

// >>> testbench/fifo_config_and_read_port_control_tb_top.sv
// Self-checking bench for FIFO configuration and read-port control
`timescale 1ns/1ps
`default_nettype none

module fifo_config_and_read_port_control_tb_top;
  logic        mclk, rst_n, full_reset_n, data_only_reset_n, write_request_n;
  logic        read_request_n, read_port_select, output_drive_enable, ldv;
  logic        serial_load_enable, offset_load_select, mode_serial_in, nd_flag, echo_rden;
  logic        read_side_clock, write_side_clock, serial_program_clock;
  logic        q_oe, echo_clock, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [8:0]  st;
  logic [11:0] ecfg;
  logic [71:0] data_in, q_out;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, eofs;
  logic [95:0] r96;
  logic [19:0] v;
  int          seed = 32'ha6ab_ec1d;
  int          n_errors = 0;
  int          n_compared = 0;
  int          echo_cnt = 0;
  int          echo_base;

  // ==========================================
  // Design, host model and clock
  fifo_cfg_ctrl #(.DEPTH(4)) fifo_cfg_ctrl_inst (
    .mclk(mclk), .rst_n(rst_n), .full_reset_n(full_reset_n),
    .data_only_reset_n(data_only_reset_n), .write_side_clock(write_side_clock),
    .write_request_n(write_request_n), .data_in(data_in),
    .read_side_clock(read_side_clock), .read_request_n(read_request_n),
    .read_port_select(read_port_select), .output_drive_enable(output_drive_enable),
    .serial_program_clock(serial_program_clock), .serial_load_enable(serial_load_enable),
    .offset_load_select(offset_load_select), .mode_serial_in(mode_serial_in),
    .default_offset_sel0(st[0]), .default_offset_sel1(st[1]),
    .flag_timing_select(st[2]), .parity_placement_select(st[3]),
    .byte_order_select(st[4]), .width_match_enable(st[5]), .in_width_sel(st[6]),
    .out_width_sel(st[7]), .read_port_level_select(st[8]), .q_out(q_out), .q_oe(q_oe),
    .no_data_flag(nd_flag), .near_empty_flag(), .near_full_flag(), .echo_clock(echo_clock),
    .echo_read_enable(echo_rden), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  pin_host pin_host_inst (.mclk(mclk), .read_side_clock(read_side_clock),
    .write_side_clock(write_side_clock), .serial_program_clock(serial_program_clock));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Echo clock watcher; the sequence notes the count before a read pulse
  always @(posedge mclk)
    if (echo_clock === 1'b1) echo_cnt <= echo_cnt + 1;

  // ==========================================
  // Checks, bus cycles and reset
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        n_errors++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Classic cycle; only the watchdog ends the wait on a dead slave
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] msk,
                    input logic [31:0] exp);
    begin
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, we, adr, 4'hf, exp};
      @(posedge mclk);
      while (wb_ack_o !== 1'b1)
        @(posedge mclk);
      if (!we) chk(wb_dat_o & msk, exp & msk);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge mclk);
    end
  endtask

  // Full reset with random straps; parallel runs keep full width for D-bit maps
  task automatic do_reset(input logic ld_s, input logic ft);
    begin
      r96 = {$random(seed), $random(seed), $random(seed)};
      {full_reset_n, read_port_select, offset_load_select} <= {2'h1, ld_s};
      mode_serial_in <= ft; // Both read modes are met in parallel runs
      st <= {r96[8:6], r96[5] & ~ld_s, r96[4:0]};
      repeat (6) @(posedge mclk);
      chk(32'(q_oe), 32'h0000_0001); // Select ignored in reset
      full_reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      ecfg = {ld_s, st[1:0], st[8:2], ~ld_s, mode_serial_in};
      offset_load_select <= 1'b1;
    end
  endtask

  task automatic report_and_stop;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // ==========================================
  // Main sequence: serial and parallel runs alternate
  initial
  begin
    {rst_n, full_reset_n, output_drive_enable, mode_serial_in} = '0;
    {data_only_reset_n, write_request_n, read_request_n, read_port_select} = '1;
    {serial_load_enable, offset_load_select, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h18;
    {st, data_in, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int it = 0; it < 4; it++)
    begin
      ldv = it[0];
      do_reset(ldv, it[1]);
      wb(1'b0, fifo_cfg_pkg::REG_STATUS, 32'h0000_fff0, {16'h0000, ecfg, 4'h0});
      eofs = {22'h00_0000, fifo_cfg_pkg::DEF_OFS[ecfg[11:9]]};
      wb(1'b0, fifo_cfg_pkg::REG_EMPTY_OFS, 32'hffff_ffff, eofs); // Default
      wb(1'b0, fifo_cfg_pkg::REG_FULL_OFS, 32'hffff_ffff, eofs); // Default
      wb(1'b1, 8'h40, 32'hffff_ffff, r96[31:0]);
      wb(1'b0, 8'h40, 32'hffff_ffff, 32'h0000_0000);
      chk(32'(q_oe), 32'h0000_0001); // Driven before read edge
      output_drive_enable <= 1'b1;
      repeat (5) @(posedge mclk);
      chk(32'(q_oe), 32'h0000_0000); // Float
      output_drive_enable <= 1'b0;
      repeat (5) @(posedge mclk);
      echo_base = echo_cnt;
      pin_host_inst.pulse(0);
      chk(32'(q_oe), 32'h0000_0000); // Deselected float
      chk(32'(echo_cnt != echo_base), 32'(st[8])); // Echo gated
      read_port_select <= 1'b0; // Host keeps select low, as retransmit or strobe use needs
      pin_host_inst.pulse(0);
      chk(32'(q_oe), 32'h0000_0001); // Selected drive
      offset_load_select <= 1'b0;
      write_request_n <= ~ldv;
      serial_load_enable <= ldv;
      v = r96[91:72];
      for (int k = 0; k < (ldv ? 2 : 24); k++)
      begin
        r96 = {$random(seed), $random(seed), $random(seed)};
        if (ldv) data_in <= r96[71:0];
        if (ldv) v[k*10 +: 10] = st[3] ? {r96[10:9], r96[7:0]} : r96[9:0];
        if (k == 20) serial_load_enable <= 1'b1;
        mode_serial_in <= v[k % 20] ^ (k >= 20);
        pin_host_inst.pulse(ldv ? 1 : 2); // Load by chosen method
      end
      {offset_load_select, write_request_n, serial_load_enable} <= 3'h7; // Memory traffic
      data_only_reset_n <= 1'b0;
      repeat (6) @(posedge mclk);
      data_only_reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      wb(1'b0, fifo_cfg_pkg::REG_EMPTY_OFS, 32'h0000_03ff, {12'h000, v}); // Kept
      wb(1'b0, fifo_cfg_pkg::REG_FULL_OFS, 32'h0000_03ff, {22'h00_0000, v[19:10]}); // Kept
      // One long word through the store; runs with width matching enabled skip this part
      if (!st[5])
      begin
        r96 = {$random(seed), $random(seed), $random(seed)};
        {write_request_n, read_port_select} <= 2'h1;
        data_in <= r96[71:0];
        pin_host_inst.pulse(1); // Memory write with load select high
        write_request_n <= 1'b1;
        repeat (3) pin_host_inst.pulse(0);
        chk(32'(nd_flag), 32'h0000_0001); // Flag ignores select
        chk(32'(q_out == (ecfg[0] ? r96[71:0] : 72'h0)), 32'h0000_0001); // Falls through
        read_port_select <= 1'b0;
        pin_host_inst.pulse(0); // Select first, request still high
        chk(32'(q_oe), 32'h0000_0001); // Bus now driven
        read_request_n <= 1'b0;
        pin_host_inst.pulse(0);
        chk(32'(q_out == r96[71:0]), 32'h0000_0001); // Selected read
        chk(32'(echo_rden), 32'(st[8])); // Echo enable gated
        read_request_n <= 1'b1;
      end
    end
    report_and_stop;
  end

  // Watchdog well beyond the thousand or fewer cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire

// >>> testbench/pin_host.sv
// Host model driving the read, write and programming clock pins
`timescale 1ns/1ps
`default_nettype none

module pin_host (
  input  wire logic mclk,
  output logic      read_side_clock,
  output logic      write_side_clock,
  output logic      serial_program_clock
);
  // ==========================================
  // Pin clocks stand still low between pulses
  initial
  begin
    read_side_clock = 1'b0;
    write_side_clock = 1'b0;
    serial_program_clock = 1'b0;
  end

  // One rise on pin 0 read, 1 write, 2 serial; 4-cycle phases beat the sync
  task automatic pulse(input int which);
    begin
      @(posedge mclk);
      if (which == 0) read_side_clock <= 1'b1;
      if (which == 1) write_side_clock <= 1'b1;
      if (which == 2) serial_program_clock <= 1'b1; // Shift clock
      repeat (4) @(posedge mclk);
      {read_side_clock, write_side_clock, serial_program_clock} <= 3'h0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire
